// ### tims_irq.sv
// tims_irq: main interrupt flags, main and auxiliary masks, irq request
`timescale 1ns/1ps
`default_nettype none

module tims_irq (
   // clock and reset
   input  wire logic                    i_ref_clk,
   input  wire logic                    i_arst_n,
   // register port from the serial host interface
   input  wire tims_pkg::tims_reg_req_t i_reg,
   output logic [7:0]                   o_reg_rdata,
   // commands and non-volatile configuration
   input  wire logic                    i_set_default,
   input  wire logic                    i_cfg_powerup_irq_enable,
   input  wire logic                    i_cfg_active_wake_irq_enable,
   // event pulses from the protocol engine
   input  wire tims_pkg::tims_evt_t     i_evt,
   // auxiliary flag register contents, kept outside
   input  wire logic [7:0]              i_aux_flags,
   // request toward the host
   output logic                         o_irq
);

   // ************************************************************
   // state
   // ************************************************************
   logic [7:0] main_mask_r;
   logic [7:0] main_mask_nxt;
   logic [7:0] aux_mask_r;
   logic [7:0] aux_mask_nxt;
   logic [7:0] flags_r;
   logic [7:0] flags_nxt;
   logic       init_pend_r;
   logic       init_pend_nxt;
   logic [7:0] rdata_nxt;
   logic       irq_nxt;
   logic [7:0] evt_set;
   logic       rd_flags;
   logic       rd_aux;

   function automatic logic hit(input tims_pkg::tims_reg_req_t r,
                                input logic [7:0] ofs);
      hit = (r.addr == ofs);
   endfunction

   // ************************************************************
   // next-state logic
   // ************************************************************
   always_comb begin
      rd_flags = i_reg.rd && hit(i_reg, tims_pkg::MAIN_FLAGS_OFS);
      rd_aux   = i_reg.rd && hit(i_reg, tims_pkg::AUX_FLAGS_OFS);

      // rx/tx events count only when the frame goes through the FIFO
      evt_set = 8'h00;
      evt_set[tims_pkg::FLAG_POWERUP_EVENT_BIT]     = i_evt.powerup;
      evt_set[tims_pkg::FLAG_ACTIVE_ENTRY_WAKE_BIT] = i_evt.active_wake;
      evt_set[tims_pkg::FLAG_COMMAND_WAKE_BIT]      = i_evt.command_wake;
      evt_set[tims_pkg::FLAG_RX_START_BIT] =
         i_evt.rx_start && i_evt.rx_in_fifo;
      evt_set[tims_pkg::FLAG_RX_END_BIT] =
         i_evt.rx_end && i_evt.rx_in_fifo;
      evt_set[tims_pkg::FLAG_TX_END_BIT] =
         i_evt.tx_end && i_evt.tx_from_fifo;
      evt_set[tims_pkg::FLAG_FIFO_LEVEL_BIT] = i_evt.fifo_level;

      // masks
      main_mask_nxt = main_mask_r;
      aux_mask_nxt  = aux_mask_r;
      init_pend_nxt = 1'b0;
      if (i_reg.wr && hit(i_reg, tims_pkg::MAIN_MASK_OFS)) begin
         main_mask_nxt = i_reg.wdata & tims_pkg::MAIN_MASK_WMSK;
      end
      if (i_reg.wr && hit(i_reg, tims_pkg::AUX_MASK_OFS)) begin
         aux_mask_nxt = i_reg.wdata;
      end
      // one-shot power-up initialisation after reset release
      if (init_pend_r) begin
         if (i_cfg_powerup_irq_enable) begin
            main_mask_nxt[tims_pkg::MASK_POWERUP_EVENT_BIT] = 1'b0;
         end
         if (i_cfg_active_wake_irq_enable) begin
            main_mask_nxt[tims_pkg::MASK_ACTIVE_ENTRY_WAKE_BIT] = 1'b0;
         end
      end
      if (i_set_default) begin
         main_mask_nxt = tims_pkg::MAIN_MASK_RST;
         aux_mask_nxt  = tims_pkg::AUX_MASK_RST;
      end

      // flags: a new event wins over the read clear
      flags_nxt = flags_r;
      if (rd_flags) begin
         flags_nxt[7:1] = 7'h00;
      end
      flags_nxt[7:1] = flags_nxt[7:1] | evt_set[7:1];
      // bit 0 follows the auxiliary register, held until that is read
      if (|i_aux_flags) begin
         flags_nxt[tims_pkg::FLAG_AUX_BIT] = 1'b1;
      end else if (rd_aux) begin
         flags_nxt[tims_pkg::FLAG_AUX_BIT] = 1'b0;
      end
      if (i_set_default) begin
         flags_nxt = tims_pkg::MAIN_FLAGS_RST;
      end

      // read data, unmapped offsets read zero
      rdata_nxt = 8'h00;
      if (i_reg.rd) begin
         unique case (i_reg.addr)
            tims_pkg::MAIN_MASK_OFS:  rdata_nxt = main_mask_r;
            tims_pkg::AUX_MASK_OFS:   rdata_nxt = aux_mask_r;
            tims_pkg::MAIN_FLAGS_OFS: rdata_nxt = flags_r;
            default:                  rdata_nxt = 8'h00;
         endcase
      end

      // mask hides only the request, never the flag
      irq_nxt = (|(flags_nxt[7:1] & ~main_mask_nxt[7:1]))
              || (|(i_aux_flags & ~aux_mask_nxt));
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         main_mask_r <= tims_pkg::MAIN_MASK_RST;
         aux_mask_r  <= tims_pkg::AUX_MASK_RST;
         flags_r     <= tims_pkg::MAIN_FLAGS_RST;
         init_pend_r <= 1'b1;
         o_reg_rdata <= 8'h00;
         o_irq       <= 1'b0;
      end else begin
         main_mask_r <= main_mask_nxt;
         aux_mask_r  <= aux_mask_nxt;
         flags_r     <= flags_nxt;
         init_pend_r <= init_pend_nxt;
         o_reg_rdata <= rdata_nxt;
         o_irq       <= irq_nxt;
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_arst_n);

   property p_pu_cfg_clear;
      init_pend_r && i_cfg_powerup_irq_enable && !i_set_default
         |=> !main_mask_r[7];
   endproperty
   a_pu_cfg_clear: assert property (p_pu_cfg_clear)
      else $error("power-up mask not cleared by config");

   property p_act_cfg_clear;
      init_pend_r && i_cfg_active_wake_irq_enable && !i_set_default
         |=> !main_mask_r[6];
   endproperty
   a_act_cfg_clear: assert property (p_act_cfg_clear)
      else $error("active wake mask not cleared by config");

   property p_mask_write;
      i_reg.wr && i_reg.addr == tims_pkg::MAIN_MASK_OFS && !i_set_default
         && !init_pend_r
         |=> main_mask_r == ($past(i_reg.wdata) & tims_pkg::MAIN_MASK_WMSK);
   endproperty
   a_mask_write: assert property (p_mask_write)
      else $error("main mask write wrong or reserved bit set");

   property p_set_default;
      i_set_default |=> main_mask_r == tims_pkg::MAIN_MASK_RST
         && aux_mask_r == tims_pkg::AUX_MASK_RST
         && flags_r == tims_pkg::MAIN_FLAGS_RST;
   endproperty
   a_set_default: assert property (p_set_default)
      else $error("set default did not restore registers");

   property p_aux_write;
      i_reg.wr && i_reg.addr == tims_pkg::AUX_MASK_OFS && !i_set_default
         |=> aux_mask_r == $past(i_reg.wdata)
             ##1 (o_reg_rdata == $past(aux_mask_r) || !$past(i_reg.rd)
                  || $past(i_reg.addr) != tims_pkg::AUX_MASK_OFS);
   endproperty
   a_aux_write: assert property (p_aux_write)
      else $error("aux mask write not stored");

   property p_evt_sets;
      i_evt.command_wake && !i_set_default |=> flags_r[5];
   endproperty
   a_evt_sets: assert property (p_evt_sets)
      else $error("command wake flag not set");

   property p_rx_gate;
      i_evt.rx_start && !i_evt.rx_in_fifo && !flags_r[4]
         |=> !flags_r[4];
   endproperty
   a_rx_gate: assert property (p_rx_gate)
      else $error("rx start flagged for frame outside FIFO");

   property p_tx_gate;
      i_evt.tx_end && !i_evt.tx_from_fifo && !flags_r[2]
         |=> !flags_r[2];
   endproperty
   a_tx_gate: assert property (p_tx_gate)
      else $error("tx end flagged for data outside FIFO");

   property p_level;
      i_evt.fifo_level && !i_set_default |=> flags_r[1];
   endproperty
   a_level: assert property (p_level)
      else $error("fifo level flag missing");

   property p_aux_sum;
      (|i_aux_flags) && !i_set_default |=> flags_r[0];
   endproperty
   a_aux_sum: assert property (p_aux_sum)
      else $error("aux summary bit not set");

   property p_read_clear;
      i_reg.rd && i_reg.addr == tims_pkg::MAIN_FLAGS_OFS && i_evt == '0
         && !i_set_default
         |=> flags_r[7:1] == 7'h00
             && (flags_r[0] == $past(flags_r[0]) || $past(|i_aux_flags));
   endproperty
   a_read_clear: assert property (p_read_clear)
      else $error("flag read clear wrong");

   property p_aux_hold;
      flags_r[0] && !rd_aux && !i_set_default
         |=> flags_r[0];
   endproperty
   a_aux_hold: assert property (p_aux_hold)
      else $error("aux summary cleared without aux read");

   property p_irq;
      ##1 o_irq == ((|(flags_r[7:1] & ~main_mask_r[7:1]))
                    || $past(|(i_aux_flags & ~aux_mask_nxt)));
   endproperty
   a_irq: assert property (p_irq)
      else $error("irq does not match unmasked flags");

   property p_pu_sets;
      i_evt.powerup && !i_set_default
         |=> flags_r[tims_pkg::FLAG_POWERUP_EVENT_BIT];
   endproperty
   a_pu_sets: assert property (p_pu_sets)
      else $error("power-up flag not set");

   property p_aw_sets;
      i_evt.active_wake && !i_set_default
         |=> flags_r[tims_pkg::FLAG_ACTIVE_ENTRY_WAKE_BIT];
   endproperty
   a_aw_sets: assert property (p_aw_sets)
      else $error("active entry wake flag not set");

   property p_rx_sets;
      i_evt.rx_end && i_evt.rx_in_fifo && !i_set_default
         |=> flags_r[tims_pkg::FLAG_RX_END_BIT];
   endproperty
   a_rx_sets: assert property (p_rx_sets)
      else $error("rx end not flagged for frame in FIFO");

   property p_tx_sets;
      i_evt.tx_end && i_evt.tx_from_fifo && !i_set_default
         |=> flags_r[tims_pkg::FLAG_TX_END_BIT];
   endproperty
   a_tx_sets: assert property (p_tx_sets)
      else $error("tx end not flagged for data from FIFO");

   property p_aux_clear;
      rd_aux && !(|i_aux_flags) && !i_set_default
         |=> !flags_r[tims_pkg::FLAG_AUX_BIT];
   endproperty
   a_aux_clear: assert property (p_aux_clear)
      else $error("aux summary not cleared by aux read");

   property p_flags_read;
      i_reg.rd && i_reg.addr == tims_pkg::MAIN_FLAGS_OFS
         |=> o_reg_rdata == $past(flags_r);
   endproperty
   a_flags_read: assert property (p_flags_read)
      else $error("flag read returned wrong value");

   c_wake_irq: cover property (i_evt.command_wake ##1 o_irq);
   c_read_clr: cover property (flags_r[3] ##1 rd_flags ##1 !flags_r[3]);
   c_aux_clr:  cover property (flags_r[0] ##1 rd_aux ##1 !flags_r[0]);
   c_masked:   cover property (flags_r[1] && main_mask_r[1] && !o_irq);
   c_def_wr:   cover property (i_set_default && i_reg.wr
                               ##1 main_mask_r == tims_pkg::MAIN_MASK_RST);

endmodule

`default_nettype wire

// ### tims_pkg.sv
// tims_pkg: constants and carriers for tag interrupt flag and mask logic
`default_nettype none
package tims_pkg;

   // ************************************************************
   // register offsets
   // ************************************************************
   localparam logic [7:0] MAIN_MASK_OFS  = 8'h08;
   localparam logic [7:0] AUX_MASK_OFS   = 8'h09;
   localparam logic [7:0] MAIN_FLAGS_OFS = 8'h0a;
   localparam logic [7:0] AUX_FLAGS_OFS  = 8'h0b;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int MASK_POWERUP_EVENT_BIT     = 7;
   localparam int MASK_ACTIVE_ENTRY_WAKE_BIT = 6;
   localparam int FLAG_POWERUP_EVENT_BIT     = 7;
   localparam int FLAG_ACTIVE_ENTRY_WAKE_BIT = 6;
   localparam int FLAG_COMMAND_WAKE_BIT      = 5;
   localparam int FLAG_RX_START_BIT          = 4;
   localparam int FLAG_RX_END_BIT            = 3;
   localparam int FLAG_TX_END_BIT            = 2;
   localparam int FLAG_FIFO_LEVEL_BIT        = 1;
   localparam int FLAG_AUX_BIT               = 0;

   // ************************************************************
   // reset values and writable bits
   // ************************************************************
   localparam logic [7:0] MAIN_MASK_RST  = 8'hc0;
   localparam logic [7:0] MAIN_MASK_WMSK = 8'hfe;
   localparam logic [7:0] AUX_MASK_RST   = 8'h00;
   localparam logic [7:0] MAIN_FLAGS_RST = 8'h00;

   // ************************************************************
   // carriers
   // ************************************************************
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } tims_reg_req_t;

   typedef struct packed {
      logic powerup;
      logic active_wake;
      logic command_wake;
      logic rx_start;
      logic rx_end;
      logic rx_in_fifo;
      logic tx_end;
      logic tx_from_fifo;
      logic fifo_level;
   } tims_evt_t;

endpackage

`default_nettype wire

// ### tims_host_model.sv
// tims_host_model: host microcontroller driving the register port
`timescale 1ns/1ps
`default_nettype none

module tims_host_model (
   // clock
   input  wire logic                    i_ref_clk,
   // register port toward the device
   output var  tims_pkg::tims_reg_req_t o_reg,
   input  wire logic [7:0]              i_reg_rdata
);
   initial o_reg = '0;

   // ************************************************************
   // one register access, request held over one rising edge
   // ************************************************************
   task automatic acc(input logic w, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] q);
      @(negedge i_ref_clk);
      o_reg = '{rd: !w, wr: w, addr: a, wdata: d};
      @(negedge i_ref_clk);
      // released lines show the inverse, not the old value
      o_reg = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
      q = i_reg_rdata;
   endtask
endmodule

`default_nettype wire

// ### tims_irq_tb_top.sv
// tims_irq_tb_top: self-checking bench for interrupt flags and masks
`timescale 1ns/1ps
`default_nettype none

module tims_irq_tb_top;
   logic                    ref_clk = 1'b0;
   logic                    arst_n = 1'b0;
   tims_pkg::tims_reg_req_t reg_req;
   logic [7:0]              reg_rdata;
   logic                    set_default = 1'b0;
   logic                    cfg_pu = 1'b0;
   logic                    cfg_aw = 1'b0;
   tims_pkg::tims_evt_t     evt = '0;
   logic [7:0]              aux_flags = 8'h00;
   logic                    irq;
   int                      err_count = 0;
   int                      comparisons = 0;
   int                      cycles = 0;
   logic [7:0]              q;
   // event pulse pattern beside the flags it should raise
   logic [16:0]             rows [9] = '{
      {9'h100, 8'h80}, {9'h080, 8'h40}, {9'h040, 8'h20},
      {9'h028, 8'h10}, {9'h018, 8'h08}, {9'h020, 8'h00},
      {9'h006, 8'h04}, {9'h004, 8'h00}, {9'h001, 8'h02}};

   tims_irq u_tims_irq (
      .i_ref_clk(ref_clk), .i_arst_n(arst_n), .i_reg(reg_req),
      .o_reg_rdata(reg_rdata), .i_set_default(set_default),
      .i_cfg_powerup_irq_enable(cfg_pu),
      .i_cfg_active_wake_irq_enable(cfg_aw),
      .i_evt(evt), .i_aux_flags(aux_flags), .o_irq(irq));

   tims_host_model u_tims_host_model (
      .i_ref_clk(ref_clk), .o_reg(reg_req), .i_reg_rdata(reg_rdata));

   always #5 ref_clk = ~ref_clk;

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         end_of_test();
      end
   end

   // ************************************************************
   // shared tasks
   // ************************************************************
   task automatic end_of_test();
      if (err_count == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic rd(input logic [7:0] a);
      u_tims_host_model.acc(1'b0, a, 8'h00, q);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      u_tims_host_model.acc(1'b1, a, d, q);
   endtask

   task automatic pulse_evt(input logic [8:0] e);
      @(negedge ref_clk);
      evt = tims_pkg::tims_evt_t'(e);
      @(negedge ref_clk);
      evt = '0;
   endtask

   task automatic do_reset(input logic [1:0] c);
      @(negedge ref_clk);
      arst_n = 1'b0;
      cfg_pu = c[1];
      cfg_aw = c[0];
      repeat (12) @(negedge ref_clk);
      arst_n = 1'b1;
   endtask

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      do_reset(2'b10);
      rd(tims_pkg::MAIN_MASK_OFS);
      chk(q, 8'h40);
      // leave state behind so the mid-run reset has work to do
      wr(tims_pkg::AUX_MASK_OFS, 8'h5a);
      pulse_evt(9'h040);
      do_reset(2'b01);
      rd(tims_pkg::MAIN_MASK_OFS);
      chk(q, 8'h80);
      rd(tims_pkg::AUX_MASK_OFS);
      chk(q, 8'h00);
      rd(tims_pkg::MAIN_FLAGS_OFS);
      chk(q, 8'h00);
      rd(8'h3f);
      chk(q, 8'h00);
      wr(tims_pkg::MAIN_MASK_OFS, 8'h00);
      foreach (rows[i]) begin
         pulse_evt(rows[i][16:8]);
         chk({7'h00, irq}, {7'h00, |rows[i][7:0]});
         // host services every flag, level one included
         rd(tims_pkg::MAIN_FLAGS_OFS);
         chk(q, rows[i][7:0]);
         rd(tims_pkg::MAIN_FLAGS_OFS);
         chk(q, 8'h00);
      end
      // masked source keeps its flag but no request
      wr(tims_pkg::MAIN_MASK_OFS, 8'hff);
      rd(tims_pkg::MAIN_MASK_OFS);
      chk(q, 8'hfe);
      pulse_evt(9'h040);
      chk({7'h00, irq}, 8'h00);
      aux_flags = 8'h04;
      @(negedge ref_clk);
      chk({7'h00, irq}, 8'h01);
      rd(tims_pkg::MAIN_FLAGS_OFS);
      chk(q, 8'h21);
      rd(tims_pkg::MAIN_FLAGS_OFS);
      chk(q, 8'h01);
      wr(tims_pkg::AUX_MASK_OFS, 8'hff);
      rd(tims_pkg::AUX_MASK_OFS);
      chk(q, 8'hff);
      chk({7'h00, irq}, 8'h00);
      aux_flags = 8'h00;
      rd(tims_pkg::AUX_FLAGS_OFS);
      rd(tims_pkg::MAIN_FLAGS_OFS);
      chk(q, 8'h00);
      // set default with a flag pending and both masks changed
      pulse_evt(9'h100);
      set_default = 1'b1;
      @(negedge ref_clk);
      set_default = 1'b0;
      rd(tims_pkg::MAIN_MASK_OFS);
      chk(q, 8'hc0);
      rd(tims_pkg::AUX_MASK_OFS);
      chk(q, 8'h00);
      rd(tims_pkg::MAIN_FLAGS_OFS);
      chk(q, 8'h00);
      chk({7'h00, irq}, 8'h00);
      // one mask bit hides only its own source
      wr(tims_pkg::MAIN_MASK_OFS, 8'h04);
      pulse_evt(9'h006);
      chk({7'h00, irq}, 8'h00);
      pulse_evt(9'h028);
      chk({7'h00, irq}, 8'h01);
      // read clear and a new event in one cycle: the event stays
      fork
         rd(tims_pkg::MAIN_FLAGS_OFS);
         pulse_evt(9'h001);
      join
      chk(q, 8'h14);
      // read data stands one cycle only
      @(negedge ref_clk);
      chk(reg_rdata, 8'h00);
      rd(tims_pkg::MAIN_FLAGS_OFS);
      chk(q, 8'h02);
      // set default beats a mask write and an event in its cycle
      fork
         wr(tims_pkg::MAIN_MASK_OFS, 8'h3e);
         pulse_evt(9'h040);
         begin
            @(negedge ref_clk);
            set_default = 1'b1;
            @(negedge ref_clk);
            set_default = 1'b0;
         end
      join
      rd(tims_pkg::MAIN_MASK_OFS);
      chk(q, 8'hc0);
      rd(tims_pkg::MAIN_FLAGS_OFS);
      chk(q, 8'h00);
      // auxiliary event in the cycle of the aux read keeps bit 0
      fork
         rd(tims_pkg::AUX_FLAGS_OFS);
         begin
            @(negedge ref_clk);
            aux_flags = 8'h01;
            @(negedge ref_clk);
            aux_flags = 8'h00;
         end
      join
      rd(tims_pkg::MAIN_FLAGS_OFS);
      chk(q, 8'h01);
      rd(tims_pkg::AUX_FLAGS_OFS);
      rd(tims_pkg::MAIN_FLAGS_OFS);
      chk(q, 8'h00);
      end_of_test();
   end
endmodule

`default_nettype wire
